// File: core/pefgp_regs.vh
// register map, reset values and field positions of the port E / port F gpio block
// assumes byte addresses on a 32-bit ahb-lite bus, low 16 bits decoded
`ifndef PEFGP_REGS_VH
`define PEFGP_REGS_VH
`define PEFGP_ADDR_W 16
`define PEFGP_OFS_DIR_E 16'hFE3C
`define PEFGP_OFS_DIR_F 16'hFE3E
`define PEFGP_OFS_DATA_F 16'hFF0E
`define PEFGP_OFS_PINS_F 16'hFFBE
`define PEFGP_OFS_PUP_E 16'hFE44
`define PEFGP_OFS_DATA_E 16'hFF0C
`define PEFGP_OFS_CTRL 16'hFE40
`define PEFGP_DIR_F_RST_EXT 8'h80
`define PEFGP_DIR_F_RST_SC 8'h00
`define PEFGP_BYTE_RST 8'h00
`define PEFGP_UNDEF_READ 8'h00
`define PEFGP_CTRL_BUS16 0
`define PEFGP_CTRL_WAITE 1
`define PEFGP_CTRL_BRLE 2
`define PEFGP_CTRL_HOLD 3
`define PEFGP_CTRL_SSBY 4
`define PEFGP_CTRL_W 5
`define PEFGP_PF_CLK 7
`define PEFGP_PF_AS 6
`define PEFGP_PF_RD 5
`define PEFGP_PF_HWR 4
`define PEFGP_PF_WAIT 2
`define PEFGP_PF_BACK 1
`define PEFGP_PF_BUS_REQUEST_IN 0
`endif

// File: core/pefgp_top.v
// port E / port F general purpose i/o with pull-up control and bus-function hand-over
// assumes one ahb-lite master, hclk at 50 MHz, pin inputs already synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
`include "pefgp_regs.vh"

module pefgp_top
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [2:0] mode,
   input wire hw_standby,
   input wire sys_clk_en,
   input wire address_strobe,
   input wire read_strobe,
   input wire high_byte_write_strobe,
   input wire bus_grant_out,
   output reg wait_in,
   output reg bus_request_in,
   input wire [7:0] data_bus_out,
   input wire data_bus_oe,
   output reg [7:0] data_bus_in,
   input wire [7:0] pe_in,
   output reg [7:0] pe_out,
   output reg [7:0] pe_oe,
   output reg [7:0] pe_pullup,
   input wire [7:0] pf_in,
   output reg [7:0] pf_out,
   output reg [7:0] pf_oe
);
   reg [7:0] dir_e_q;
   reg [7:0] data_e_q;
   reg [7:0] pull_up_ctrl_e_q;
   reg [7:0] dir_f_q;
   reg [7:0] data_f_q;
   reg [`PEFGP_CTRL_W-1:0] ctrl_q;
   reg wr_pend_q;
   reg [15:0] wr_addr_q;
   reg [7:0] pe_out_d;
   reg [7:0] pe_oe_d;
   reg [7:0] pe_pullup_d;
   reg [7:0] pf_out_d;
   reg [7:0] pf_oe_d;
   wire [7:0] pins_f_w;
   reg [31:0] rdata_d;
   reg hw_standby_q;
   wire ext_mode;
   wire sc_mode;
   wire bus16;
   wire waite;
   wire brle;
   wire hold_sel;
   wire soft_sby;
   wire pe_port;
   wire acc;
   wire [15:0] a16;
   wire [7:0] wbyte;
   wire clr_regs;
   genvar gi;

   assign ext_mode = (mode == 3'h4) || (mode == 3'h5) || (mode == 3'h6);
   assign sc_mode = (mode == 3'h7);
   assign bus16 = ctrl_q[`PEFGP_CTRL_BUS16];
   assign waite = ctrl_q[`PEFGP_CTRL_WAITE];
   assign brle = ctrl_q[`PEFGP_CTRL_BRLE];
   assign hold_sel = ctrl_q[`PEFGP_CTRL_HOLD];
   assign soft_sby = ctrl_q[`PEFGP_CTRL_SSBY];
   // port E is a port in mode 7 and in the external modes outside the 16-bit bus configuration
   assign pe_port = (ext_mode && !bus16) || sc_mode;
   assign acc = hsel && hready && htrans[1];
   assign a16 = haddr[15:0];
   assign wbyte = hwdata[7:0];

   // readback picks, bit by bit, the stored output level or the live pin
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_pins_f
         assign pins_f_w[gi] = dir_f_q[gi] ? data_f_q[gi] : pf_in[gi];
      end
   endgenerate

   // registers write in the data phase following the address phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 16'h0000;
      end
      else
      begin
         wr_pend_q <= acc && hwrite;
         wr_addr_q <= a16;
      end
   end

   // hardware standby clears like reset and keeps clearing one cycle after it
   // drops; the flag starts set so the first clocked cycle also clears
   assign clr_regs = hw_standby || hw_standby_q;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hw_standby_q <= 1'b1;
      end
      else
      begin
         hw_standby_q <= hw_standby;
      end
   end

   // software standby only gates pins; register contents stay put
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dir_e_q <= `PEFGP_BYTE_RST;
      end
      else if (clr_regs)
      begin
         dir_e_q <= `PEFGP_BYTE_RST;
      end
      else if (wr_pend_q && (wr_addr_q == `PEFGP_OFS_DIR_E))
      begin
         dir_e_q <= wbyte;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         data_e_q <= `PEFGP_BYTE_RST;
      end
      else if (clr_regs)
      begin
         data_e_q <= `PEFGP_BYTE_RST;
      end
      else if (wr_pend_q && (wr_addr_q == `PEFGP_OFS_DATA_E))
      begin
         data_e_q <= wbyte;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pull_up_ctrl_e_q <= `PEFGP_BYTE_RST;
      end
      else if (clr_regs)
      begin
         pull_up_ctrl_e_q <= `PEFGP_BYTE_RST;
      end
      else if (wr_pend_q && (wr_addr_q == `PEFGP_OFS_PUP_E))
      begin
         pull_up_ctrl_e_q <= wbyte;
      end
   end

   // the mode strap is only valid after reset release, so dir_f takes its
   // mode-dependent value from hardware standby or the first clocked cycle
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dir_f_q <= `PEFGP_DIR_F_RST_SC;
      end
      else if (clr_regs)
      begin
         dir_f_q <= ext_mode ? `PEFGP_DIR_F_RST_EXT : `PEFGP_DIR_F_RST_SC;
      end
      else if (wr_pend_q && (wr_addr_q == `PEFGP_OFS_DIR_F))
      begin
         dir_f_q <= wbyte;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         data_f_q <= `PEFGP_BYTE_RST;
      end
      else if (clr_regs)
      begin
         data_f_q <= `PEFGP_BYTE_RST;
      end
      else if (wr_pend_q && (wr_addr_q == `PEFGP_OFS_DATA_F))
      begin
         data_f_q <= wbyte;
      end
   end

   // control bits select bus width, wait, bus release, hold and standby
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q <= {`PEFGP_CTRL_W{1'b0}};
      end
      else if (clr_regs)
      begin
         ctrl_q <= {`PEFGP_CTRL_W{1'b0}};
      end
      else if (wr_pend_q && (wr_addr_q == `PEFGP_OFS_CTRL))
      begin
         ctrl_q <= hwdata[`PEFGP_CTRL_W-1:0];
      end
   end

   // pin mux for both ports
   always @*
   begin
      pe_out_d = data_e_q;
      pe_oe_d = 8'h00;
      pe_pullup_d = 8'h00;
      if (ext_mode && bus16)
      begin
         pe_out_d = data_bus_out;
         pe_oe_d = {8{data_bus_oe}};
      end
      else if (pe_port)
      begin
         pe_oe_d = dir_e_q;
         pe_pullup_d = ~dir_e_q & pull_up_ctrl_e_q;
      end
      pf_out_d = data_f_q;
      pf_oe_d = dir_f_q;
      pf_out_d[`PEFGP_PF_CLK] = sys_clk_en;
      if (ext_mode)
      begin
         pf_out_d[`PEFGP_PF_AS] = address_strobe;
         pf_out_d[`PEFGP_PF_RD] = read_strobe;
         pf_out_d[`PEFGP_PF_HWR] = high_byte_write_strobe;
         pf_oe_d[6:4] = 3'h7;
         if (waite)
         begin
            pf_oe_d[`PEFGP_PF_WAIT] = 1'b0;
         end
         if (brle)
         begin
            pf_out_d[`PEFGP_PF_BACK] = bus_grant_out;
            pf_oe_d[`PEFGP_PF_BACK] = 1'b1;
            pf_oe_d[`PEFGP_PF_BUS_REQUEST_IN] = 1'b0;
         end
         // strobes float in software standby unless hold is selected
         if (soft_sby && !hold_sel)
         begin
            pf_oe_d[6:4] = 3'h0;
            if (brle)
            begin
               pf_oe_d[`PEFGP_PF_BACK] = 1'b0;
            end
         end
      end
      rdata_d = 32'h00000000;
      case (a16)
         `PEFGP_OFS_DIR_F: rdata_d[7:0] = `PEFGP_UNDEF_READ;
         `PEFGP_OFS_DIR_E: rdata_d[7:0] = `PEFGP_UNDEF_READ;
         `PEFGP_OFS_DATA_F: rdata_d[7:0] = data_f_q;
         `PEFGP_OFS_DATA_E: rdata_d[7:0] = data_e_q;
         `PEFGP_OFS_PINS_F: rdata_d[7:0] = pins_f_w;
         `PEFGP_OFS_PUP_E: rdata_d[7:0] = pull_up_ctrl_e_q;
         `PEFGP_OFS_CTRL: rdata_d[`PEFGP_CTRL_W-1:0] = ctrl_q;
         default: rdata_d = 32'h00000000;
      endcase
   end

   // outputs registered; in software standby with hold selected the strobe
   // pins keep the last driven level, which is what holding means here
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wait_in <= 1'b1;
         bus_request_in <= 1'b1;
         data_bus_in <= 8'h00;
         pe_out <= 8'h00;
         pe_oe <= 8'h00;
         pe_pullup <= 8'h00;
         pf_out <= 8'h00;
         pf_oe <= 8'h00;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (acc && !hwrite)
         begin
            hrdata <= rdata_d;
         end
         wait_in <= (ext_mode && waite) ? pf_in[`PEFGP_PF_WAIT] : 1'b1;
         bus_request_in <= (ext_mode && brle) ? pf_in[`PEFGP_PF_BUS_REQUEST_IN] : 1'b1;
         data_bus_in <= pe_in;
         pe_out <= pe_out_d;
         pe_oe <= pe_oe_d;
         pe_pullup <= (hw_standby || hw_standby_q) ? 8'h00 : pe_pullup_d;
         if (ext_mode && soft_sby && hold_sel)
         begin
            pf_out <= {pf_out_d[7], pf_out[6:4], pf_out_d[3:0]};
         end
         else
         begin
            pf_out <= pf_out_d;
         end
         pf_oe <= pf_oe_d;
      end
   end
endmodule
`default_nettype wire

// File: verification/pefgp_sva.sv
// port relations of pefgp_top checked on every rising hclk edge
// assumes one clock domain and asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module pefgp_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] mode,
   input wire logic hw_standby,
   input wire logic sys_clk_en,
   input wire logic address_strobe,
   input wire logic read_strobe,
   input wire logic high_byte_write_strobe,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic wait_in,
   input wire logic bus_request_in,
   input wire logic [7:0] pe_oe,
   input wire logic [7:0] pe_pullup,
   input wire logic [7:0] pf_out,
   input wire logic [7:0] pf_oe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_pu_out; (pe_pullup & pe_oe) == 8'h00; endproperty
   a_pu_out: assert property (p_pu_out) else $error("pull-up on driven pin");
   property p_pu_hws; hw_standby |=> pe_pullup == 8'h00; endproperty
   a_pu_hws: assert property (p_pu_hws) else $error("pull-up in standby");
   property p_strb; pf_oe[6] && mode != 3'h7 |->
      pf_out[6:4] == $past({address_strobe, read_strobe, high_byte_write_strobe}); endproperty
   a_strb: assert property (p_strb) else $error("strobe level wrong");
   property p_strb_oe; mode != 3'h7 && !hw_standby |=> pf_oe[6:4] == 3'h7; endproperty
   a_strb_oe: assert property (p_strb_oe) else $error("strobe not driven");
   property p_clk; pf_oe[7] |-> pf_out[7] == $past(sys_clk_en); endproperty
   a_clk: assert property (p_clk) else $error("clock pin wrong");
   property p_m7; mode == 3'h7 |=> wait_in && bus_request_in; endproperty
   a_m7: assert property (p_m7) else $error("bus input in mode 7");
   property p_ok; hreadyout && !hresp; endproperty
   a_ok: assert property (p_ok) else $error("bus not ready or error");
   property p_hi; hrdata[31:8] == 24'h000000; endproperty
   a_hi: assert property (p_hi) else $error("read data upper bits");
endmodule
bind pefgp_top pefgp_sva u_sva (.*);
`default_nettype wire

// File: verification/port_e_f_gpio_pullup_bench.sv
// self-checking bench for pefgp_top over ahb-lite
// assumes the checker binds itself; mode changes only under reset
`timescale 1ns/1ps
`default_nettype none
`include "pefgp_regs.vh"
module port_e_f_gpio_pullup_bench;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hw_standby = 0, sys_clk_en = 0;
   logic address_strobe = 0, read_strobe = 0, high_byte_write_strobe = 0;
   logic bus_grant_out = 0, data_bus_oe = 0, hreadyout, hresp, wait_in, bus_request_in;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rng = 32'h4DE3;
   logic [1:0] htrans = 0;
   logic [2:0] mode = 3'h4;
   logic [7:0] data_bus_out = 0, pe_in = 0, pf_in = 0, data_bus_in, pe_out, pe_oe;
   logic [7:0] pe_pullup, pf_out, pf_oe, r, d, m;
   int mismatches = 0, n_tests = 0;
   pefgp_top dut (.*, .hready(hreadyout), .hsize(3'h2));
   initial forever #10 hclk = ~hclk;
   function logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task step;
      rng = xs(rng);
   endtask
   function logic [7:0] rdbk(input logic [7:0] dr, dt, pin);
      return (dt & dr) | (pin & ~dr);
   endfunction
   task chk(input string nm, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task bus(input logic [15:0] a, input logic w, input logic [7:0] v);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {16'h0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, v};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata[7:0];
   endtask
   task rst(input logic [2:0] md);
      @(posedge hclk);
      hresetn <= 1'b0;
      mode <= md;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #400000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      rst(3'h4);
      #1 chk("pf_oe7", pf_oe[7], 1'b1);
      bus(`PEFGP_OFS_DIR_F, 1'b0, 8'h00);
      chk("dir_f", r, `PEFGP_UNDEF_READ);
      bus(`PEFGP_OFS_DATA_F, 1'b0, 8'h00);
      chk("data_f", r, `PEFGP_BYTE_RST);
      bus(`PEFGP_OFS_PUP_E, 1'b0, 8'h00);
      chk("pup_e", r, `PEFGP_BYTE_RST);
      bus(16'h0000, 1'b0, 8'h00);
      chk("unmapped", r, 8'h00);
      bus(`PEFGP_OFS_DIR_E, 1'b1, 8'h0F);
      bus(`PEFGP_OFS_PUP_E, 1'b1, 8'hFF);
      @(posedge hclk);
      #1 chk("pe_pullup", pe_pullup, 8'hF0);
      chk("pe_oe", pe_oe, 8'h0F);
      bus(`PEFGP_OFS_CTRL, 1'b1, 8'h07);
      repeat (8)
      begin
         step();
         @(posedge hclk);
         {address_strobe, read_strobe, high_byte_write_strobe, sys_clk_en} <= rng[3:0];
         data_bus_oe <= 1'b1;
         data_bus_out <= rng[15:8];
         pf_in <= rng[23:16];
         pe_in <= rng[31:24];
         repeat (2) @(posedge hclk);
         #1 chk("bus_in", data_bus_in, pe_in);
         chk("bus_pull", pe_pullup, 8'h00);
         chk("bus_oe", pe_oe, 8'hFF);
         chk("bus_out", pe_out, data_bus_out);
         chk("wait", {7'h00, wait_in}, {7'h00, pf_in[2]});
         chk("bus_request_in", {7'h00, bus_request_in}, {7'h00, pf_in[0]});
      end
      rst(3'h7);
      #1 chk("pf_oe_m7", pf_oe, `PEFGP_DIR_F_RST_SC);
      repeat (8)
      begin
         step();
         d = rng[7:0];
         m = rng[15:8];
         pf_in <= rng[23:16];
         sys_clk_en <= rng[24];
         bus(`PEFGP_OFS_DIR_F, 1'b1, m);
         bus(`PEFGP_OFS_DATA_F, 1'b1, d);
         bus(`PEFGP_OFS_DIR_E, 1'b1, m);
         bus(`PEFGP_OFS_PUP_E, 1'b1, d);
         bus(`PEFGP_OFS_DATA_E, 1'b1, d);
         bus(`PEFGP_OFS_PINS_F, 1'b0, 8'h00);
         chk("pins_f", r, rdbk(m, d, pf_in));
         #1 chk("pf_oe", pf_oe, m);
         chk("pf_out", {1'b0, pf_out[6:0]}, {1'b0, d[6:0]});
         chk("pe_oe7", pe_oe, m);
         chk("pe_out7", pe_out, d);
         chk("pup7", pe_pullup, d & ~m);
      end
      @(posedge hclk);
      hw_standby <= 1'b1;
      repeat (3) @(posedge hclk);
      hw_standby <= 1'b0;
      repeat (3) @(posedge hclk);
      bus(`PEFGP_OFS_DATA_F, 1'b0, 8'h00);
      chk("data_f_hws", r, `PEFGP_BYTE_RST);
      bus(`PEFGP_OFS_PUP_E, 1'b0, 8'h00);
      chk("pup_hws", r, `PEFGP_BYTE_RST);
      #1 chk("dir_f_hws", pf_oe, `PEFGP_DIR_F_RST_SC);
      complete_run();
   end
endmodule
`default_nettype wire
